// file: bst_cfg.svh
/*
  Constants of the boundary-scan test port: instruction encodings,
  register lengths, reset values and sampling counts.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef BST_CFG_SVH
`define BST_CFG_SVH
`define BST_IR_LEN 4
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h6
`define BST_OP_USERSIG 4'h7
`define BST_OP_CFGLOAD 4'h8
`define BST_OP_CFGDATA 4'h9
`define BST_OP_CFGDONE 4'ha
`define BST_OP_BYPASS 4'hf
`define BST_IR_CAPTURE 4'h1
// Arbitrary identity value, names no real maker or part
`define BST_ID_CODE 32'h0a5c_3001
`define BST_USER_SIG 32'h0000_0000
`define BST_BSR_LEN 8
`define BST_CFG_LEN 16
`define BST_TLR_TMS_CNT 5
`define BST_MIN_PERIOD_NS 100
`define BST_MCLK_NS 20
`endif

// file: bst_pkg.sv
/*
  Types of the boundary-scan test port.
  Assumes the constants header is on the include path.
*/
`include "bst_cfg.svh"
package bst_pkg;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
    SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
    UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
    E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
  } bst_state_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;
  typedef struct packed {
    logic tdo;
    logic tdoEnN;
  } bst_out_t;
endpackage : bst_pkg

// file: bst_sync.sv
/*
  Two-flop synchroniser for the test pins, plus rising/falling edge strobes.
  Assumes pins are asynchronous to mclk and change slower than mclk.
*/
`timescale 1ns/10ps
module bst_sync
  import bst_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync,
  output logic tckRise,
  output logic tckFall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic tckLast;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;
  logic next_tckLast;

  always_comb begin
    next_meta = pinIn;
    next_sync = meta;
    next_tckLast = sync[WIDTH-1];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
      tckLast <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      tckLast <= next_tckLast;
    end
  end

  assign pinSync = sync;
  assign tckRise = sync[WIDTH-1] & ~tckLast;
  assign tckFall = ~sync[WIDTH-1] & tckLast;
endmodule : bst_sync

// file: bst_tap.sv
/*
  Boundary-scan test access port: controller, instruction register and
  data registers (bypass, identity, user signature, boundary, config load).
  Assumes test pins arrive asynchronously and mclk is far faster than tck.
*/
`timescale 1ns/10ps
`include "bst_cfg.svh"
module bst_tap
  import bst_pkg::*;
#(
  parameter int BSR_LEN = `BST_BSR_LEN,
  parameter int CFG_LEN = `BST_CFG_LEN,
  parameter logic [31:0] ID_CODE = `BST_ID_CODE,
  parameter logic [31:0] USER_SIG = `BST_USER_SIG
) (
  input wire logic mclk,
  input wire logic rst,
  input wire bst_pkg::bst_pins_t testPins,
  input wire logic [BSR_LEN-1:0] pinsIn,
  input wire logic [BSR_LEN-1:0] coreOut,
  output bst_pkg::bst_out_t testOut,
  output logic [BSR_LEN-1:0] pinsOut,
  output logic cfgBusy,
  output logic cfgDone,
  output logic [CFG_LEN-1:0] cfgWord,
  output logic cfgWordValid
);
  localparam int IRL = `BST_IR_LEN;
  localparam int DRL = (BSR_LEN > 32) ? ((CFG_LEN > BSR_LEN) ? CFG_LEN : BSR_LEN)
                     : ((CFG_LEN > 32) ? CFG_LEN : 32);
  // Shortest legal tck period, in mclk cycles
  localparam int TCK_MIN_CYC = (`BST_MIN_PERIOD_NS + `BST_MCLK_NS - 1) / `BST_MCLK_NS;

  bst_pins_t pinSync;
  logic tckRise;
  logic tckFall;

  bst_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(testPins),
    .pinSync(pinSync),
    .tckRise(tckRise),
    .tckFall(tckFall)
  );

  // Board pins are asynchronous to mclk; no edge strobes wanted here
  logic [BSR_LEN-1:0] pinsInSync;

  bst_sync #(.WIDTH(BSR_LEN)) u_pinSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(pinsIn),
    .pinSync(pinsInSync),
    .tckRise(),
    .tckFall()
  );

  bst_state_t state;
  bst_state_t next_state;
  logic [IRL-1:0] irShift;
  logic [IRL-1:0] ir;
  logic [DRL-1:0] drShift;
  logic [BSR_LEN-1:0] bsrUpdate;
  logic [BSR_LEN-1:0] pinsOutR;
  logic tdoR;
  logic tdoEnNR;
  logic busyR;
  logic doneR;
  logic [CFG_LEN-1:0] cfgWordR;
  logic cfgValidR;
  logic [IRL-1:0] next_irShift;
  logic [IRL-1:0] next_ir;
  logic [DRL-1:0] next_drShift;
  logic [BSR_LEN-1:0] next_bsrUpdate;
  logic [BSR_LEN-1:0] next_pinsOutR;
  logic next_tdoR;
  logic next_tdoEnNR;
  logic next_busyR;
  logic next_doneR;
  logic [CFG_LEN-1:0] next_cfgWordR;
  logic next_cfgValidR;
  logic [31:0] drLen;
  logic tdoBit;

  // Controller transition on tck rising edge
  always_comb begin
    next_state = state;
    if (tckRise) begin
      case (state)
        TLR: next_state = pinSync.tms ? TLR : RTI;
        RTI: next_state = pinSync.tms ? SDS : RTI;
        SDS: next_state = pinSync.tms ? SIS : CDR;
        CDR: next_state = pinSync.tms ? E1D : SDR;
        SDR: next_state = pinSync.tms ? E1D : SDR;
        E1D: next_state = pinSync.tms ? UDR : PDR;
        PDR: next_state = pinSync.tms ? E2D : PDR;
        E2D: next_state = pinSync.tms ? UDR : SDR;
        UDR: next_state = pinSync.tms ? SDS : RTI;
        SIS: next_state = pinSync.tms ? TLR : CIR;
        CIR: next_state = pinSync.tms ? E1I : SIR;
        SIR: next_state = pinSync.tms ? E1I : SIR;
        E1I: next_state = pinSync.tms ? UIR : PIR;
        PIR: next_state = pinSync.tms ? E2I : PIR;
        E2I: next_state = pinSync.tms ? UIR : SIR;
        UIR: next_state = pinSync.tms ? SDS : RTI;
        default: next_state = TLR;
      endcase
    end
  end

  // Selected data register length; unknown opcodes fall back to bypass
  always_comb begin
    case (ir)
      `BST_OP_EXTEST, `BST_OP_SAMPLE: drLen = 32'(BSR_LEN);
      `BST_OP_IDCODE, `BST_OP_USERSIG: drLen = 32'd32;
      `BST_OP_CFGDATA: drLen = 32'(CFG_LEN);
      default: drLen = 32'd1;
    endcase
  end

  assign tdoBit = (state == SIR) ? irShift[0] : drShift[0];

  // Register datapath on tck edges
  always_comb begin
    next_irShift = irShift;
    next_ir = ir;
    next_drShift = drShift;
    next_bsrUpdate = bsrUpdate;
    next_busyR = busyR;
    next_doneR = doneR;
    next_cfgWordR = cfgWordR;
    next_cfgValidR = 1'b0;
    next_tdoR = tdoR;
    next_tdoEnNR = tdoEnNR;
    if (tckRise) begin
      case (state)
        TLR: begin
          next_ir = `BST_OP_IDCODE;
        end
        CIR: next_irShift = `BST_IR_CAPTURE;
        SIR: next_irShift = {pinSync.tdi, irShift[IRL-1:1]};
        UIR: begin
          next_ir = irShift;
          if (irShift == `BST_OP_CFGLOAD) begin
            next_busyR = 1'b1;
            next_doneR = 1'b0;
          end else if (irShift == `BST_OP_CFGDONE && busyR) begin
            next_busyR = 1'b0;
            next_doneR = 1'b1;
          end
        end
        CDR: begin
          next_drShift = '0;
          case (ir)
            `BST_OP_EXTEST, `BST_OP_SAMPLE:
              next_drShift[BSR_LEN-1:0] = pinsInSync;
            `BST_OP_IDCODE: next_drShift[31:0] = ID_CODE;
            `BST_OP_USERSIG: next_drShift[31:0] = USER_SIG;
            default: next_drShift[0] = 1'b0;
          endcase
        end
        SDR: begin
          next_drShift = drShift >> 1;
          next_drShift[drLen-1] = pinSync.tdi;
        end
        UDR: begin
          if (ir == `BST_OP_EXTEST || ir == `BST_OP_SAMPLE)
            next_bsrUpdate = drShift[BSR_LEN-1:0];
          if (ir == `BST_OP_CFGDATA && busyR) begin
            next_cfgWordR = drShift[CFG_LEN-1:0];
            next_cfgValidR = 1'b1;
          end
        end
        default: next_ir = ir;
      endcase
    end
    // Output changes on falling tck, enabled only while shifting
    if (tckFall) begin
      next_tdoR = tdoBit;
      next_tdoEnNR = !(state == SDR || state == SIR);
    end
  end

  // Boundary drive: update stage only under external test
  always_comb begin
    next_pinsOutR = (ir == `BST_OP_EXTEST) ? bsrUpdate : coreOut;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= TLR;
      irShift <= '0;
      ir <= `BST_OP_IDCODE;
      drShift <= '0;
      bsrUpdate <= '0;
      pinsOutR <= '0;
      tdoR <= 1'b0;
      tdoEnNR <= 1'b1;
      busyR <= 1'b0;
      doneR <= 1'b0;
      cfgWordR <= '0;
      cfgValidR <= 1'b0;
    end else begin
      state <= next_state;
      irShift <= next_irShift;
      ir <= next_ir;
      drShift <= next_drShift;
      bsrUpdate <= next_bsrUpdate;
      pinsOutR <= next_pinsOutR;
      tdoR <= next_tdoR;
      tdoEnNR <= next_tdoEnNR;
      busyR <= next_busyR;
      doneR <= next_doneR;
      cfgWordR <= next_cfgWordR;
      cfgValidR <= next_cfgValidR;
    end
  end

  assign testOut = {tdoR, tdoEnNR};
  assign pinsOut = pinsOutR;
  assign cfgBusy = busyR;
  assign cfgDone = doneR;
  assign cfgWord = cfgWordR;
  assign cfgWordValid = cfgValidR;
endmodule : bst_tap

// file: bst_tap_checker.sv
/* Assertion checker bound to bst_tap, watching only its ports.
   Assumes tck phases last four mclk cycles or more. */
`timescale 1ns/10ps
module bst_tap_checker
  import bst_pkg::*;
#(
  parameter int BSR_LEN = 8,
  parameter int CFG_LEN = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire bst_pkg::bst_pins_t testPins,
  input wire logic [BSR_LEN-1:0] pinsIn,
  input wire logic [BSR_LEN-1:0] coreOut,
  input wire bst_pkg::bst_out_t testOut,
  input wire logic [BSR_LEN-1:0] pinsOut,
  input wire logic cfgBusy,
  input wire logic cfgDone,
  input wire logic [CFG_LEN-1:0] cfgWord,
  input wire logic cfgWordValid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence tck_low;
    !$past(testPins.tck) && !$past(testPins.tck, 2);
  endsequence
  a_reset_outs: assert property ($fell(rst) |-> testOut.tdoEnN && !pinsOut)
    else $error("bad reset state");
  a_tdo_fall: assert property (!$stable(testOut) |-> tck_low)
    else $error("tdo moved off tck fall");
  a_cfg_rise: assert property ($rose(cfgBusy) || cfgWordValid |-> $past(testPins.tck))
    else $error("config moved off tck rise");
  a_done_busy: assert property ($rose(cfgDone) |-> $past(cfgBusy))
    else $error("done without busy");
  a_cfg_excl: assert property (!(cfgBusy && cfgDone)) else $error("busy and done");
  a_valid_pulse: assert property (cfgWordValid |=> !cfgWordValid) else $error("long");
  a_valid_busy: assert property (cfgWordValid |-> cfgBusy) else $error("word idle");
  a_word_hold: assert property (!$stable(cfgWord) |-> cfgWordValid)
    else $error("word changed silently");
endmodule : bst_tap_checker
bind bst_tap bst_tap_checker #(.BSR_LEN(BSR_LEN), .CFG_LEN(CFG_LEN)) u_chk (
  .mclk(mclk), .rst(rst), .testPins(testPins), .pinsIn(pinsIn), .coreOut(coreOut),
  .testOut(testOut), .pinsOut(pinsOut), .cfgBusy(cfgBusy), .cfgDone(cfgDone),
  .cfgWord(cfgWord), .cfgWordValid(cfgWordValid));

// file: bst_ctl_model.sv
/* Test controller model driving the three test pins.
   Assumes calls start just after an mclk edge. */
`timescale 1ns/10ps
module bst_ctl_model
  import bst_pkg::*;
(
  output bst_pkg::bst_pins_t pins,
  input wire bst_pkg::bst_out_t tOut
);
  initial pins = '0;
  // Tck idles low; tdo taken just before the fall
  // Released tdo reads inverted, so a missing enable shows up as bad data
  task automatic step(input logic tms, input logic tdi, output logic tdoBit);
    pins.tms = tms;
    pins.tdi = tdi;
    #80 pins.tck = 1'b1;
    #80 tdoBit = tOut.tdoEnN ? ~tOut.tdo : tOut.tdo;
    pins.tck = 1'b0;
  endtask : step
  task automatic to_idle;
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : to_idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : scan
endmodule : bst_ctl_model

// file: bst_tap_tb.sv
/* Self-checking bench for bst_tap.
   Assumes the controller model and the bound checker. */
`timescale 1ns/10ps
`include "bst_cfg.svh"
module bst_tap_tb;
  import bst_pkg::*;
  localparam logic [31:0] SIG = 32'h5a3c_96e1;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  bst_pins_t pins;
  bst_out_t tOut;
  logic [7:0] pinsIn = 8'h00;
  logic [7:0] coreOut = 8'h00;
  logic [7:0] pinsOut, p;
  logic cfgBusy, cfgDone, cfgWordValid;
  logic [15:0] cfgWord;
  logic [31:0] d, r;
  int seed = 32'h315e;
  int err_count = 0;
  int checks = 0;
  always #10 mclk = ~mclk;
  bst_tap #(.USER_SIG(SIG)) dut (.mclk(mclk), .rst(rst), .testPins(pins), .pinsIn(pinsIn),
    .coreOut(coreOut), .testOut(tOut), .pinsOut(pinsOut), .cfgBusy(cfgBusy),
    .cfgDone(cfgDone), .cfgWord(cfgWord), .cfgWordValid(cfgWordValid));
  bst_ctl_model ctl (.pins(pins), .tOut(tOut));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic ir(input logic [3:0] op);
    ctl.scan(1'b1, 4, {28'h0, op}, d);
  endtask : ir
  task automatic dr(input int n);
    r = $random(seed);
    ctl.scan(1'b0, n, r, d);
  endtask : dr
  task automatic new_pins;
    @(posedge mclk);
    #1 r = $random(seed);
    {pinsIn, coreOut} = r[15:0];
  endtask : new_pins
  function automatic logic [31:0] byp(input logic [31:0] din);
    return {24'h0, din[6:0], 1'b0};
  endfunction : byp
  task finish_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    new_pins();
    ctl.to_idle();
    dr(32);
    check(d, `BST_ID_CODE);
    ir(`BST_OP_USERSIG);
    check(d, `BST_IR_CAPTURE);
    dr(32);
    check(d, SIG);
    for (int i = 0; i < 2; i++) begin
      ir(i ? 4'h3 : `BST_OP_BYPASS);
      dr(8);
      check(d, byp(r));
    end
    ir(`BST_OP_SAMPLE);
    dr(8);
    p = r[7:0];
    check(d, pinsIn);
    check(pinsOut, coreOut);
    ir(`BST_OP_EXTEST);
    check(pinsOut, p);
    new_pins();
    dr(8);
    check(d, pinsIn);
    check(pinsOut, r[7:0]);
    ir(`BST_OP_CFGDATA);
    dr(16);
    check(cfgWord, 16'h0);
    ir(`BST_OP_CFGLOAD);
    check({cfgBusy, cfgDone}, 2'b10);
    ir(`BST_OP_CFGDATA);
    dr(16);
    check(cfgWord, r[15:0]);
    ir(`BST_OP_CFGDONE);
    check({cfgBusy, cfgDone}, 2'b01);
    ctl.to_idle();
    dr(32);
    check(d, `BST_ID_CODE);
    finish_test();
  end
endmodule : bst_tap_tb
